// >>> design/uar_pkg.sv
package uar_pkg;
	// Oversampling per bit
	localparam int unsigned SAMPLES_NORMAL = 16;
	localparam int unsigned SAMPLES_DOUBLE = 8;
	// Centre vote samples, numbered from 1
	localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
	localparam logic [4:0] VOTE_LAST_NORMAL  = 5'h0A;
	localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
	localparam logic [4:0] VOTE_LAST_DOUBLE  = 5'h06;
	// Frame length limits, data plus parity
	localparam logic [3:0] BITS_MIN          = 4'h5;
	localparam logic [3:0] BITS_MAX          = 4'hA;
	// Reset values
	localparam logic [4:0] SAMPLE_RESET      = 5'h00;
	localparam logic [3:0] BIT_RESET         = 4'h0;
	localparam logic [9:0] DATA_RESET        = 10'h000;
	localparam logic [2:0] SYNC_RESET        = 3'h7;
	// Receiver states
	typedef enum logic [1:0] {
		UAR_IDLE,
		UAR_START,
		UAR_BITS,
		UAR_STOP
	} uar_state_t;
endpackage : uar_pkg

// >>> design/uar_sync.sv
// Three-stage pin synchroniser with agreement filter
module uar_sync (
	input  wire logic clock,     // System clock
	input  wire logic rst_b,     // Synchronous reset, active low
	input  wire logic pin_in,    // Asynchronous line
	output logic      level_out  // Filtered level
);
	import uar_pkg::*;

	logic [2:0] sync_reg;
	logic [2:0] sync_next;
	logic       level_reg;
	logic       level_next;

	// Stage one feeds only stage two; stages two and three must agree
	always_comb begin
		sync_next  = {sync_reg[1:0], pin_in};
		level_next = level_reg;
		if (sync_reg[1] == sync_reg[2]) begin
			level_next = sync_reg[2];
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			sync_reg  <= SYNC_RESET;
			level_reg <= 1'b1;
		end else begin
			sync_reg  <= sync_next;
			level_reg <= level_next;
		end
	end

	assign level_out = level_reg;
endmodule : uar_sync

// >>> design/uar_vote.sv
// Three-sample majority over the centre window
module uar_vote (
	input  wire logic       clock,      // System clock
	input  wire logic       rst_b,      // Synchronous reset, active low
	input  wire logic       clear,      // Start a new bit
	input  wire logic       take,       // Capture this sample
	input  wire logic       sample,     // Line level
	output logic            majority    // Vote of captured samples
);
	import uar_pkg::*;

	logic [2:0] win_reg;
	logic [2:0] win_next;

	always_comb begin
		win_next = win_reg;
		if (clear) begin
			win_next = 3'h0;
		end else if (take) begin
			win_next = {win_reg[1:0], sample};
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			win_reg <= 3'h0;
		end else begin
			win_reg <= win_next;
		end
	end

	// Two or three highs give one
	assign majority = (win_reg[0] & win_reg[1]) | (win_reg[0] & win_reg[2]) | (win_reg[1] & win_reg[2]);
endmodule : uar_vote

// >>> design/uar_rx_recovery.sv
// Operation
// R1: Sample line sixteen times per bit normally, eight in double speed.
// R2: Idle-high samples count as zero; wait for a start condition.
// R3: High-to-low edge starts qualification; first low sample is number one.
// R4: Start decided by samples 8,9,10 normal or 4,5,6 double speed.
// R5: Two or more high qualification samples reject start as noise.
// R6: Each accepted start bit re-aligns the bit sampling phase.
// R7: Per-bit counter has sixteen or eight states numbering each sample.
// R8: Bit value is majority of three centre samples.
// R9: Recover data, optional parity and first stop bit; ignore more.
// R10: Low first stop bit sets the frame error indication.
// R11: Ready for next start right after last stop vote sample.
// R12: Frames carry five to ten data-plus-parity bits.
// R13: Transmitter keeps rate within receiver acceptance window.
// R14: Each side takes half the tolerable rate error.
// R15: Frame error travels with its frame to the buffer.
// R16: Double speed affects asynchronous operation only.
// R17: Double speed ignores lows before stop voting window ends.
module uar_rx_recovery (
	input  wire logic       clock,               // System clock, 100 MHz
	input  wire logic       rst_b,               // Synchronous reset, active low
	input  wire logic       sample_tick,         // Baud sample tick, one cycle
	input  wire logic       serial_rx_line,      // Receive pin, asynchronous
	input  wire logic       double_speed_select, // 1 selects 8x oversampling
	input  wire logic [3:0] frame_bits,          // Data plus parity, 5 to 10
	output logic            frame_valid,         // One-cycle frame strobe
	output logic [9:0]      frame_data,          // Recovered bits, LSB first
	output logic            frame_error_flag,    // Stop bit was low
	output logic            rx_busy              // Frame in progress
);
	import uar_pkg::*;

	uar_state_t state_reg;
	uar_state_t state_next;
	logic [4:0] sample_reg;
	logic [4:0] sample_next;
	logic [3:0] bit_reg;
	logic [3:0] bit_next;
	logic [9:0] data_reg;
	logic [9:0] data_next;
	logic       fe_reg;
	logic       fe_next;
	logic       valid_reg;
	logic       valid_next;
	logic       prev_reg;
	logic       prev_next;
	logic       line;
	logic       vote;
	logic       vote_clear;
	logic       vote_take;
	logic [4:0] spb;
	logic [4:0] vote_first;
	logic [4:0] vote_last;
	logic [3:0] bits_eff;

	uar_sync u_sync (
		.clock     (clock),
		.rst_b     (rst_b),
		.pin_in    (serial_rx_line),
		.level_out (line)
	);

	uar_vote u_vote (
		.clock    (clock),
		.rst_b    (rst_b),
		.clear    (vote_clear),
		.take     (vote_take),
		.sample   (line),
		.majority (vote)
	);

	// R14: receiver rate error is set by the tick source, not here
	// R16: no synchronous mode exists here, select only changes oversampling
	// R1: samples per bit and R4: vote window by mode
	assign spb        = double_speed_select ? 5'(SAMPLES_DOUBLE) : 5'(SAMPLES_NORMAL);
	assign vote_first = double_speed_select ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
	assign vote_last  = double_speed_select ? VOTE_LAST_DOUBLE : VOTE_LAST_NORMAL;

	// R12: clamp length into five..ten
	assign bits_eff = (frame_bits < BITS_MIN) ? BITS_MIN : ((frame_bits > BITS_MAX) ? BITS_MAX : frame_bits);

	// Vote capture only inside the centre window
	// Line seen at a tick is sample number sample_reg plus one
	assign vote_take  = sample_tick && (state_reg != UAR_IDLE)
		&& (sample_reg >= vote_first - 5'h01) && (sample_reg <= vote_last - 5'h01);
	assign vote_clear = sample_tick && (state_reg != UAR_IDLE) && (sample_reg == 5'h01);

	// Frame recovery sequencer
	always_comb begin
		state_next  = state_reg;
		sample_next = sample_reg;
		bit_next    = bit_reg;
		data_next   = data_reg;
		fe_next     = fe_reg;
		valid_next  = 1'b0;
		prev_next   = prev_reg;
		if (sample_tick) begin
			prev_next = line;
			case (state_reg)
				UAR_IDLE: begin
					// R2: idle samples numbered zero
					sample_next = SAMPLE_RESET;
					// R3: high-to-low edge, this low is sample one
					if (prev_reg && !line) begin
						state_next  = UAR_START;
						sample_next = 5'h01;
					end
				end
				UAR_START: begin
					// R7: counter numbers each sample
					sample_next = sample_reg + 5'h01;
					// R5: reject noise after last qualification sample
					if (sample_reg == vote_last) begin
						if (vote) begin
							state_next  = UAR_IDLE;
							sample_next = SAMPLE_RESET;
						end
					end
					// R6: re-align phase at this start bit
					if (sample_reg == spb) begin
						state_next  = UAR_BITS;
						sample_next = 5'h01;
						bit_next    = BIT_RESET;
					end
				end
				UAR_BITS: begin
					sample_next = sample_reg + 5'h01;
					// R8: register majority after centre window
					if (sample_reg == vote_last) begin
						data_next = data_reg;
						data_next[bit_reg] = vote;
					end
					if (sample_reg == spb) begin
						sample_next = 5'h01;
						bit_next    = bit_reg + 4'h1;
						// R9: after last data/parity bit, first stop bit only
						if (bit_reg == bits_eff - 4'h1) begin
							state_next = UAR_STOP;
						end
					end
				end
				UAR_STOP: begin
					sample_next = sample_reg + 5'h01;
					// R10: R11: vote done, flag error, return to search at once
					if (sample_reg == vote_last) begin
						fe_next    = !vote;
						valid_next = 1'b1;
						state_next = UAR_IDLE;
						sample_next = SAMPLE_RESET;
						// R17: low seen at the decision tick, just after the stop window, is not an edge
						prev_next  = 1'b1;
					end
				end
				default: begin
					state_next  = UAR_IDLE;
					sample_next = SAMPLE_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state_reg  <= UAR_IDLE;
			sample_reg <= SAMPLE_RESET;
			bit_reg    <= BIT_RESET;
			data_reg   <= DATA_RESET;
			fe_reg     <= 1'b0;
			valid_reg  <= 1'b0;
			prev_reg   <= 1'b1;
		end else begin
			state_reg  <= state_next;
			sample_reg <= sample_next;
			bit_reg    <= bit_next;
			data_reg   <= data_next;
			fe_reg     <= fe_next;
			valid_reg  <= valid_next;
			prev_reg   <= prev_next;
		end
	end

	// R15: error flag stands beside its frame data
	assign frame_valid      = valid_reg;
	assign frame_data       = data_reg;
	assign frame_error_flag = fe_reg;
	assign rx_busy          = (state_reg != UAR_IDLE);

	// Decision tick: line there is the sample after the centre window
	sequence s_start_vote;
		sample_tick && state_reg == UAR_START && sample_reg == vote_last;
	endsequence

	// Bit decisions use the same tick as the start decision
	sequence s_bit_vote;
		sample_tick && state_reg == UAR_BITS && sample_reg == vote_last;
	endsequence

	// Stop decision, the frame ends here
	sequence s_stop_vote;
		sample_tick && state_reg == UAR_STOP && sample_reg == vote_last;
	endsequence

	// Idle line seen falling between two ticks
	sequence s_idle_edge;
		sample_tick && state_reg == UAR_IDLE && prev_reg && !line;
	endsequence

	// Last start sample, phase wraps here
	sequence s_start_end;
		sample_tick && state_reg == UAR_START && sample_reg == spb;
	endsequence

	// Last sample of the final data or parity bit
	sequence s_last_bit;
		sample_tick && state_reg == UAR_BITS && sample_reg == spb && bit_reg == bits_eff - 4'h1;
	endsequence

	// Stop bit and frame output checks
	// R10: flag follows stop vote
	a_stop_error_flag: assert property (@(posedge clock) disable iff (!rst_b) // R10
		s_stop_vote |=> frame_error_flag == !$past(vote))
		else $error("frame error mismatch");

	// R11: back to search at once
	a_ready_after_stop: assert property (@(posedge clock) disable iff (!rst_b) // R11
		s_stop_vote |=> state_reg == UAR_IDLE && frame_valid)
		else $error("not idle after stop");

	// R17: low at the decision tick is no edge
	a_stop_guard: assert property (@(posedge clock) disable iff (!rst_b) // R17
		s_stop_vote |=> prev_reg)
		else $error("stop window low taken as edge");

	// R15: strobe lasts one cycle
	a_valid_single: assert property (@(posedge clock) disable iff (!rst_b) // R15
		frame_valid |=> !frame_valid)
		else $error("frame strobe too long");

	// R15: error flag changes only with its frame
	a_error_hold: assert property (@(posedge clock) disable iff (!rst_b) // R15
		!frame_valid |-> $stable(frame_error_flag))
		else $error("error flag moved without frame");

	// Start qualification checks
	// R5: majority high rejects start
	a_noise_reject: assert property (@(posedge clock) disable iff (!rst_b) // R5
		s_start_vote ##0 vote |=> state_reg == UAR_IDLE)
		else $error("noise start kept");

	// R5: rejected start stays silent
	a_noise_silent: assert property (@(posedge clock) disable iff (!rst_b) // R5
		s_start_vote ##0 vote |=> !rx_busy && !frame_valid)
		else $error("rejected start shows activity");

	// R4: majority low keeps start
	a_start_accept: assert property (@(posedge clock) disable iff (!rst_b) // R4
		s_start_vote ##0 !vote |=> state_reg == UAR_START)
		else $error("valid start dropped");

	// R3: edge begins qualification
	a_start_edge: assert property (@(posedge clock) disable iff (!rst_b) // R3
		s_idle_edge |=> state_reg == UAR_START && sample_reg == 5'h01)
		else $error("edge missed");

	// Data bit checks
	// R8: vote lands in its bit
	a_bit_capture: assert property (@(posedge clock) disable iff (!rst_b) // R8
		s_bit_vote |=> data_reg[$past(bit_reg)] == $past(vote))
		else $error("bit vote not stored");

	// R9: stop follows the last bit
	a_stop_entry: assert property (@(posedge clock) disable iff (!rst_b) // R9
		s_last_bit |=> state_reg == UAR_STOP)
		else $error("stop bit not entered");

	// Counter and mode checks
	// R7: counter stays inside one bit
	a_counter_range: assert property (@(posedge clock) disable iff (!rst_b) // R7
		sample_reg <= spb)
		else $error("sample count out of range");

	// R6: phase restarts at each start bit
	a_phase_realign: assert property (@(posedge clock) disable iff (!rst_b) // R6
		s_start_end |=> state_reg == UAR_BITS && sample_reg == 5'h01)
		else $error("no realign");

	// R2
	a_idle_zero: assert property (@(posedge clock) disable iff (!rst_b) state_reg == UAR_IDLE && $past(state_reg) == UAR_IDLE && $past(sample_tick) && !$past(prev_reg && !line) |-> sample_reg == 5'h00) else $error("idle sample nonzero"); // R2
	// R9
	a_bit_limit: assert property (@(posedge clock) disable iff (!rst_b) state_reg == UAR_BITS |-> bit_reg < bits_eff) else $error("too many bits"); // R9
	// R1
	a_mode_rate: assert property (@(posedge clock) disable iff (!rst_b) spb == (double_speed_select ? 5'h08 : 5'h10)) else $error("wrong oversample"); // R1
endmodule : uar_rx_recovery

// >>> verification/uar_tx_model.sv
// Remote serial transmitter driving the receive line
module uar_tx_model (
	input  wire logic clock,       // System clock
	input  wire logic sample_tick, // Oversample tick shared with receiver
	output logic      line         // Serial line, idle high
);
	timeunit 1ns;
	timeprecision 1ps;
	initial line = 1'b1;

	// rate tied to receiver tick
	// Zero rate error keeps both halves of the budget unused
	task automatic hold(input logic v, input int n);
		line <= v;
		repeat (n) @(posedge clock iff sample_tick);
	endtask : hold

	// Start, bits LSB first, then stop of chosen length
	task automatic send(input logic [9:0] d, input int nb, input int spb, input int slen, input logic sv);
		int i;
		hold(1'b0, spb);
		for (i = 0; i < nb; i++) begin
			hold(d[i], spb);
		end
		hold(sv, slen);
		// Only a low stop needs release; keeps back-to-back starts single-driven
		if (!sv) begin
			line <= 1'b1;
		end
	endtask : send

	// Short low spike, shorter than a start bit centre
	task automatic spike(input int n);
		hold(1'b0, n);
		line <= 1'b1;
	endtask : spike
endmodule : uar_tx_model

// >>> verification/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clock = 0;
	logic       rst_b = 0;
	logic       sample_tick = 0;
	logic       double_speed_select = 0;
	logic [3:0] frame_bits = 4'h8;
	logic       serial_rx_line;
	logic       frame_valid;
	logic       frame_error_flag;
	logic       rx_busy;
	logic [9:0] frame_data;
	logic       fv_d = 0;
	int         fails = 0;
	int         n_tests = 0;
	int         cnt = 0;
	int         spb = 16;
	logic [9:0] qd[$];
	logic       qe[$];

	uar_rx_recovery u_uar_rx_recovery (.clock(clock), .rst_b(rst_b), .sample_tick(sample_tick),
		.serial_rx_line(serial_rx_line), .double_speed_select(double_speed_select),
		.frame_bits(frame_bits), .frame_valid(frame_valid), .frame_data(frame_data),
		.frame_error_flag(frame_error_flag), .rx_busy(rx_busy));
	uar_tx_model u_uar_tx_model (.clock(clock), .sample_tick(sample_tick), .line(serial_rx_line));

	always #5 clock = ~clock;

	// Tick every fifth clock, gives sync latency room inside one sample
	always @(posedge clock) begin
		cnt <= (cnt == 4) ? 0 : cnt + 1;
		sample_tick <= (cnt == 4);
	end

	// Capture a clock late, error flag lands with the strobe and holds
	always @(posedge clock) begin
		fv_d <= frame_valid;
		if (fv_d === 1'b1) begin
			qd.push_back(frame_data);
			qe.push_back(frame_error_flag);
		end
	end

	task automatic chk(input logic [9:0] e, input logic [9:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk

	task automatic complete_run;
		if (fails == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : complete_run

	// Bounded wait for idle, then let the capture land
	task automatic settle;
		int i;
		for (i = 0; i < 2000 && rx_busy !== 1'b0; i++) @(posedge clock);
		if (i == 2000) begin
			fails++;
			complete_run();
		end
		repeat (20) @(posedge clock);
	endtask : settle

	task automatic mode(input logic m, input int nb);
		@(posedge clock);
		double_speed_select <= m;
		frame_bits <= nb[3:0];
		spb = m ? 8 : 16;
	endtask : mode

	// Pop one frame, compare the used data bits only, then the error flag
	task automatic expect_frame(input logic [9:0] d, input int nb, input logic fe);
		logic [9:0] m;
		m = 10'h3FF >> (10 - nb);
		if (qd.size() == 0) begin
			chk(10'h001, 10'h000);
			return;
		end
		chk(d & m, qd.pop_front() & m);
		chk({9'h000, fe}, {9'h000, qe.pop_front()});
	endtask : expect_frame

	task automatic t_sizes;
		int m;
		int nb;
		for (m = 0; m < 2; m++) begin
			for (nb = 5; nb <= 10; nb++) begin
				mode(m[0], nb);
				u_uar_tx_model.send(10'h2A5 ^ 10'(nb), nb, spb, spb, 1'b1);
				settle();
				expect_frame(10'h2A5 ^ 10'(nb), nb, 1'b0);
			end
		end
	endtask : t_sizes

	task automatic t_ferr;
		mode(1'b0, 8);
		u_uar_tx_model.send(10'h0F0, 8, spb, spb, 1'b0);
		settle();
		expect_frame(10'h0F0, 8, 1'b1);
		u_uar_tx_model.send(10'h00F, 8, spb, spb, 1'b1);
		settle();
		expect_frame(10'h00F, 8, 1'b0);
	endtask : t_ferr

	task automatic t_noise;
		mode(1'b0, 8);
		u_uar_tx_model.spike(3);
		settle();
		repeat (400) @(posedge clock);
		chk(10'h000, 10'(qd.size()));
		u_uar_tx_model.send(10'h0C3, 8, spb, spb, 1'b1);
		settle();
		expect_frame(10'h0C3, 8, 1'b0);
	endtask : t_noise

	// Next start right after the stop vote, in both modes
	task automatic t_b2b;
		int m;
		for (m = 0; m < 2; m++) begin
			mode(m[0], 8);
			u_uar_tx_model.send(10'h05A, 8, spb, spb / 2 + 3, 1'b1);
			u_uar_tx_model.send(10'h0A5, 8, spb, spb, 1'b1);
			settle();
			expect_frame(10'h05A, 8, 1'b0);
			expect_frame(10'h0A5, 8, 1'b0);
		end
	endtask : t_b2b

	initial begin
		repeat (10) @(posedge clock);
		rst_b <= 1'b1;
		repeat (6) @(posedge clock);
		t_sizes();
		t_ferr();
		t_noise();
		t_b2b();
		complete_run();
	end
endmodule : tb_top
